/* File: cfm_pkg.sv */
package cfm_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_PC1 = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h16;
  localparam logic [7:0] ADDR_CLS = 8'h20;
  localparam logic [7:0] ADDR_OPTIONS = 8'h21;
  localparam logic [7:0] ADDR_PG_DELAY = 8'h22;

  localparam logic [7:0] PC1_RESET = 8'h00;
  localparam logic [7:0] CLS_RESET = 8'h1B;
  localparam logic [7:0] OPT_RESET = 8'h00;
  localparam logic [7:0] PG_DELAY_RESET = 8'h00;
  localparam logic [7:0] STATUS_IDLE = 8'hFE;

  // protection_config_one fields
  localparam int PC1_TRE = 7;
  localparam int PC1_TRC = 5;
  localparam int PC1_OTC = 4;
  localparam int PC1_OCC = 3;
  localparam int PC1_UVC = 2;

  // protection_status fields, a set bit means no event
  localparam int ST_TW = 7;
  localparam int ST_PG = 6;
  localparam int ST_TR = 5;
  localparam int ST_OT = 4;
  localparam int ST_OC = 3;
  localparam int ST_UV = 2;
  localparam int ST_OV = 1;

  // current_limit_setting fields
  localparam int CLS_TCE = 4;
  localparam int CLS_SLOPE_LSB = 5;

  // monitor option fields
  localparam int OPT_PG_HI110 = 0;
  localparam int OPT_PG_LO95 = 1;
  localparam int OPT_UV_CRIT = 2;
  localparam int OPT_OT_CRIT = 3;
  localparam int OPT_PG_AT_CMD = 4;

  // ----------------------------------------------------------------
  // thresholds
  // ----------------------------------------------------------------
  localparam logic [7:0] TW_SET_C = 8'h78;
  localparam logic [7:0] TW_CLR_C = 8'h75;
  localparam logic [7:0] OT_TRIP_C = 8'h78;
  localparam logic [7:0] OT_RESTART_C = 8'h6E;
  localparam logic [7:0] PG_HI_LOW_PCT = 8'h69;
  localparam logic [7:0] PG_HI_HIGH_PCT = 8'h6E;
  localparam logic [7:0] PG_LO_LOW_PCT = 8'h5A;
  localparam logic [7:0] PG_LO_HIGH_PCT = 8'h5F;
  localparam logic [7:0] UV_PCT_DEFAULT = 8'h55;
  localparam logic [7:0] OC_BASE_PCT = 8'h25;
  localparam logic [7:0] OC_STEP_PCT = 8'h0A;
  localparam logic [7:0] OC_MAX_PCT = 8'h8C;
  localparam logic [3:0] OC_MAX_CODE = 4'hB;
  localparam logic [7:0] TC_ROOM_C = 8'h19;
  localparam int TC_SHIFT = 2;
  localparam logic [23:0] PCT_DIV = 24'h000064;
  localparam logic [15:0] TRACK_LIMIT_MV = 16'h00FA;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 50_000_000;
  localparam int MS_PER_S = 1000;
  localparam int CYC_PER_MS = CLK_HZ / MS_PER_S;
  localparam logic [7:0] PG_DELAY_MAX_MS = 8'h96;
  localparam logic [7:0] RETRY_MS = 8'h82;

  typedef enum logic [1:0] {
    PG_IDLE = 2'b00,
    PG_DELAY = 2'b01,
    PG_RELEASED = 2'b10,
    PG_HELD = 2'b11
  } cfm_pg_state_t;

endpackage

/* File: cfm_ms_tick.sv */
module cfm_ms_tick import cfm_pkg::*; #(
  parameter int CYCLES = CYC_PER_MS
) (
  input wire logic ref_clk, // system clock
  input wire logic rst,     // async reset, active high
  output logic tick         // one-cycle pulse per millisecond
);
  generate
    if (CYCLES < 2) begin : g_bad
      $error("cfm_ms_tick: CYCLES must be at least 2");
    end
  endgenerate

  logic [31:0] cnt;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt <= 32'h00000000;
      tick <= 1'b0;
    end else if (cnt == 32'(CYCLES - 1)) begin
      cnt <= 32'h00000000;
      tick <= 1'b1;
    end else begin
      cnt <= cnt + 32'h00000001;
      tick <= 1'b0;
    end
  end
endmodule

/* File: cfm_hyst_flag.sv */
module cfm_hyst_flag (
  input wire logic ref_clk,           // system clock
  input wire logic rst,               // async reset, active high
  input wire logic sample,            // new measurement valid
  input wire logic [7:0] value,       // measurement
  input wire logic [7:0] set_above,   // set when value exceeds this
  input wire logic [7:0] clear_below, // clear when value drops below
  output logic flag                   // hysteresis output
);
  // the gap between the two limits keeps the flag from chattering
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      flag <= 1'b0;
    end else if (sample && value > set_above) begin
      flag <= 1'b1;
    end else if (sample && value < clear_below) begin
      flag <= 1'b0;
    end
  end
endmodule

/* File: cfm_fault_monitor.sv */
// Summary of operation
// - warnings never turn the converter off
// - thermal warning above 120C, clears below 117C
// - power-good low outside selectable voltage window
// - power-good armed at steady state, delayed release
// - power-good warning pulls pin, clears status
// - external low on pin is a warning
// - pin drops at command or at ramp-down
// - voltage limits scale with present output setpoint
// - power-good stays active while margining
// - faults turn off; UV/OT style selectable
// - overcurrent above prebias trips both switches
// - low nibble selects overcurrent threshold percent
// - bit 4 enables temperature compensation of limit
// - top three bits select load-regulation slope
// - undervoltage in steady state, no overcurrent
// - overtemperature above 120C ramps output down, or turns both switches off when OT is critical
// - non-latching overtemperature restarts below 110C
// - tracking error over 250mV trips both switches
// - tracking check can be disabled
// - status zero means fault; write one clears latched faults
// - non-latching OC, UV and tracking faults retry every 130ms
// - protection config bit 7 enables tracking check
module cfm_fault_monitor import cfm_pkg::*; #(
  parameter int MS_TICK_CYCLES = CYC_PER_MS,
  parameter logic [15:0] IOUT_FULL_MA = 16'h4E20,
  parameter logic [7:0] UV_PCT = UV_PCT_DEFAULT
) (
  input wire logic ref_clk,           // 50 MHz system clock
  input wire logic rst,               // async reset, active high
  input wire logic [7:0] reg_addr,    // register address
  input wire logic [7:0] reg_wdata,   // register write data
  input wire logic reg_wr,            // register write strobe
  input wire logic reg_rd,            // register read strobe
  output logic [7:0] reg_rdata,       // read data, valid after reg_rd
  input wire logic sample_valid,      // new measurement set
  input wire logic [15:0] vout_mv,    // measured output voltage
  input wire logic [15:0] vset_mv,    // present setpoint incl margin
  input wire logic [15:0] vtarget_mv, // ramp target during ramp-up
  input wire logic [15:0] iout_ma,    // measured output current
  input wire logic [7:0] temp_c,      // controller temperature
  input wire logic power_on,          // converter commanded on
  input wire logic steady_state,      // output at its set level
  input wire logic ramping_up,        // output ramping up
  input wire logic ramping_down,      // output ramping down
  input wire logic above_prebias,     // output above prebias level
  input wire logic turn_off_cmd,      // turn-off command level
  input wire logic pg_in,             // level seen on power-good pin
  output logic pg_out,                // pin drive value, always low
  output logic pg_oe_n,               // low while pulling the pin
  output logic switches_off_now,      // both switches off at once
  output logic ramp_down_req,         // sequenced ramp-down request
  output logic restart_req,           // one-cycle restart pulse
  output logic [2:0] load_regulation_slope // slope code to regulator
);
  generate
    if (MS_TICK_CYCLES < 2) begin : g_bad_tick
      $error("cfm_fault_monitor: MS_TICK_CYCLES below 2");
    end
  endgenerate

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] pct_of(input logic [15:0] v,
                                         input logic [7:0] p);
    logic [23:0] prod;
    prod = 24'(v) * 24'(p);
    pct_of = 16'(prod / PCT_DIV);
  endfunction

  function automatic logic [7:0] oc_pct(input logic [3:0] code);
    logic [7:0] step;
    step = 8'(code) * OC_STEP_PCT;
    // codes past the top one hold the top limit
    if (code >= OC_MAX_CODE) begin
      oc_pct = OC_MAX_PCT;
    end else begin
      oc_pct = OC_BASE_PCT + step;
    end
  endfunction

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0] protection_config_one;
  logic [7:0] current_limit_setting;
  logic [7:0] monitor_options;
  logic [7:0] pg_delay_ms;
  logic [7:0] protection_status;
  logic wr_pc1, wr_cls, wr_opt, wr_dly, wr_st;

  assign wr_pc1 = reg_wr && reg_addr == ADDR_PC1;
  assign wr_cls = reg_wr && reg_addr == ADDR_CLS;
  assign wr_opt = reg_wr && reg_addr == ADDR_OPTIONS;
  assign wr_dly = reg_wr && reg_addr == ADDR_PG_DELAY;
  assign wr_st = reg_wr && reg_addr == ADDR_STATUS;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      protection_config_one <= PC1_RESET;
      current_limit_setting <= CLS_RESET;
      monitor_options <= OPT_RESET;
      pg_delay_ms <= PG_DELAY_RESET;
    end else begin
      if (wr_pc1) begin
        protection_config_one <= reg_wdata;
      end
      // whole byte is written; software keeps slope and comp bits
      if (wr_cls) begin
        current_limit_setting <= reg_wdata;
      end
      if (wr_opt) begin
        monitor_options <= reg_wdata;
      end
      if (wr_dly) begin
        pg_delay_ms <= reg_wdata;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        ADDR_PC1: reg_rdata <= protection_config_one;
        ADDR_CLS: reg_rdata <= current_limit_setting;
        ADDR_OPTIONS: reg_rdata <= monitor_options;
        ADDR_PG_DELAY: reg_rdata <= pg_delay_ms;
        ADDR_STATUS: reg_rdata <= protection_status;
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  assign load_regulation_slope =
    current_limit_setting[CLS_SLOPE_LSB +: 3];

  logic tracking_check_enable, trc, otc, occ, uvc, uv_crit, ot_crit;
  assign tracking_check_enable = protection_config_one[PC1_TRE];
  assign trc = protection_config_one[PC1_TRC];
  assign otc = protection_config_one[PC1_OTC];
  assign occ = protection_config_one[PC1_OCC];
  assign uvc = protection_config_one[PC1_UVC];
  assign uv_crit = monitor_options[OPT_UV_CRIT];
  assign ot_crit = monitor_options[OPT_OT_CRIT];

  // ----------------------------------------------------------------
  // thresholds, voltage ones scaled from the live setpoint, current from IOUT_FULL_MA
  // ----------------------------------------------------------------
  logic [7:0] pg_hi_pct, pg_lo_pct, oc_lim_pct, tc_add;
  logic [15:0] pg_hi_mv, pg_lo_mv, uv_mv, oc_lim_ma, track_err;
  logic in_window;

  assign pg_hi_pct = monitor_options[OPT_PG_HI110] ? PG_HI_HIGH_PCT
                                                   : PG_HI_LOW_PCT;
  assign pg_lo_pct = monitor_options[OPT_PG_LO95] ? PG_LO_HIGH_PCT
                                                  : PG_LO_LOW_PCT;
  assign pg_hi_mv = pct_of(vset_mv, pg_hi_pct);
  assign pg_lo_mv = pct_of(vset_mv, pg_lo_pct);
  assign uv_mv = pct_of(vset_mv, UV_PCT);
  // follows vset_mv through margining moves as well
  assign in_window = vout_mv <= pg_hi_mv && vout_mv >= pg_lo_mv;

  // coarse copper compensation: limit rises above room temperature
  assign tc_add = (current_limit_setting[CLS_TCE] && temp_c > TC_ROOM_C)
                  ? 8'((temp_c - TC_ROOM_C) >> TC_SHIFT) : 8'h00;
  assign oc_lim_pct = oc_pct(current_limit_setting[3:0]) + tc_add;
  assign oc_lim_ma = pct_of(IOUT_FULL_MA, oc_lim_pct);

  assign track_err = vout_mv > vtarget_mv ? vout_mv - vtarget_mv
                                          : vtarget_mv - vout_mv;

  // ----------------------------------------------------------------
  // event detection on each sample
  // ----------------------------------------------------------------
  logic flt_oc, flt_uv, flt_ot, flt_tr;
  logic oc_evt, uv_evt, ot_evt, tr_evt, tw_flag, ms_tick;

  assign oc_evt = sample_valid && power_on && above_prebias
                  && iout_ma >= oc_lim_ma;
  assign uv_evt = sample_valid && power_on && steady_state
                  && vout_mv < uv_mv && !oc_evt && !flt_oc;
  assign ot_evt = sample_valid && temp_c > OT_TRIP_C;
  assign tr_evt = sample_valid && power_on && ramping_up && tracking_check_enable
                  && track_err > TRACK_LIMIT_MV;

  cfm_hyst_flag u_tw (
    .ref_clk(ref_clk),
    .rst(rst),
    .sample(sample_valid),
    .value(temp_c),
    .set_above(TW_SET_C),
    .clear_below(TW_CLR_C),
    .flag(tw_flag)
  );

  cfm_ms_tick #(.CYCLES(MS_TICK_CYCLES)) u_tick (
    .ref_clk(ref_clk),
    .rst(rst),
    .tick(ms_tick)
  );

  // ----------------------------------------------------------------
  // fault latches and retry
  // ----------------------------------------------------------------
  logic [7:0] retry_cnt;
  logic retry_busy, retry_fire, ot_recover;

  assign retry_busy = (flt_oc && !occ) || (flt_uv && !uvc)
                      || (flt_tr && !trc);
  assign retry_fire = retry_busy && ms_tick
                      && retry_cnt == RETRY_MS - 8'h01;
  assign ot_recover = flt_ot && !otc && sample_valid
                      && temp_c < OT_RESTART_C;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      retry_cnt <= 8'h00;
    end else if (!retry_busy || retry_fire) begin
      retry_cnt <= 8'h00;
    end else if (ms_tick) begin
      retry_cnt <= retry_cnt + 8'h01;
    end
  end

  // a new event wins over a clear in the same cycle
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      flt_oc <= 1'b0;
    end else if (oc_evt) begin
      flt_oc <= 1'b1;
    end else if ((wr_st && reg_wdata[ST_OC] && occ)
                 || (retry_fire && !occ)) begin
      flt_oc <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      flt_uv <= 1'b0;
    end else if (uv_evt) begin
      flt_uv <= 1'b1;
    end else if ((wr_st && reg_wdata[ST_UV] && uvc)
                 || (retry_fire && !uvc)) begin
      flt_uv <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      flt_tr <= 1'b0;
    end else if (tr_evt) begin
      flt_tr <= 1'b1;
    end else if ((wr_st && reg_wdata[ST_TR] && trc)
                 || (retry_fire && !trc)) begin
      flt_tr <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      flt_ot <= 1'b0;
    end else if (ot_evt) begin
      flt_ot <= 1'b1;
    end else if ((wr_st && reg_wdata[ST_OT] && otc) || ot_recover) begin
      flt_ot <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      restart_req <= 1'b0;
    end else begin
      restart_req <= retry_fire || ot_recover;
    end
  end

  // warnings are left out of both shutdown paths on purpose
  assign switches_off_now = flt_oc || flt_tr || (flt_uv && uv_crit)
                            || (flt_ot && ot_crit);
  assign ramp_down_req = (flt_uv && !uv_crit)
                         || (flt_ot && !ot_crit);

  // ----------------------------------------------------------------
  // power-good pin
  // ----------------------------------------------------------------
  cfm_pg_state_t pg_state, next_pg_state;
  logic [7:0] pg_ms_cnt, pg_delay_eff;
  logic pg_drop;

  assign pg_delay_eff = pg_delay_ms > PG_DELAY_MAX_MS ? PG_DELAY_MAX_MS
                                                      : pg_delay_ms;
  assign pg_drop = !power_on || ramping_down
                   || (turn_off_cmd && monitor_options[OPT_PG_AT_CMD]);

  always_comb begin
    next_pg_state = pg_state;
    case (pg_state)
      PG_IDLE: begin
        if (!pg_drop && steady_state) begin
          next_pg_state = PG_DELAY;
        end
      end
      PG_DELAY: begin
        if (pg_drop) begin
          next_pg_state = PG_IDLE;
        end else if (pg_ms_cnt >= pg_delay_eff && in_window) begin
          next_pg_state = PG_RELEASED;
        end
      end
      PG_RELEASED: begin
        if (pg_drop) begin
          next_pg_state = PG_IDLE;
        end else if (!in_window || !pg_in) begin
          next_pg_state = PG_HELD;
        end
      end
      PG_HELD: begin
        if (pg_drop) begin
          next_pg_state = PG_IDLE;
        end else if (in_window) begin
          next_pg_state = PG_RELEASED;
        end
      end
      default: next_pg_state = PG_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pg_state <= PG_IDLE;
    end else begin
      pg_state <= next_pg_state;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pg_ms_cnt <= 8'h00;
    end else if (pg_state != PG_DELAY) begin
      pg_ms_cnt <= 8'h00;
    end else if (ms_tick && pg_ms_cnt < PG_DELAY_MAX_MS) begin
      pg_ms_cnt <= pg_ms_cnt + 8'h01;
    end
  end

  // open collector: only ever pulls low, released means high impedance
  assign pg_out = 1'b0;
  assign pg_oe_n = pg_state == PG_RELEASED;

  // ----------------------------------------------------------------
  // status, low means active
  // ----------------------------------------------------------------
  always_comb begin
    protection_status = STATUS_IDLE;
    protection_status[ST_TW] = !tw_flag;
    protection_status[ST_PG] = pg_state != PG_HELD;
    protection_status[ST_TR] = !flt_tr;
    protection_status[ST_OT] = !flt_ot;
    protection_status[ST_OC] = !flt_oc;
    protection_status[ST_UV] = !flt_uv;
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  chk_tw_set_hold: assert property (
    sample_valid && temp_c > TW_SET_C |=> !protection_status[ST_TW])
    else $error("thermal warning not raised");
  chk_warn_no_off: assert property (
    !flt_oc && !flt_uv && !flt_ot && !flt_tr
    |-> !switches_off_now && !ramp_down_req)
    else $error("shutdown without a fault");
  chk_oc_fast_off: assert property (
    oc_evt |=> switches_off_now && !protection_status[ST_OC])
    else $error("overcurrent did not trip");
  chk_uv_seq_off: assert property (
    uv_evt && !uv_crit |=> ramp_down_req && !protection_status[ST_UV])
    else $error("undervoltage ramp-down missing");
  chk_ot_trip: assert property (
    ot_evt |=> flt_ot ##0 (switches_off_now || ramp_down_req))
    else $error("overtemperature not latched");
  chk_tr_disabled: assert property (
    !tracking_check_enable && !flt_tr |=> !flt_tr)
    else $error("tracking fault while disabled");
  chk_pg_pin_drive: assert property (
    pg_state == PG_HELD |-> !pg_oe_n && !protection_status[ST_PG])
    else $error("power-good warning without pulling pin");
  chk_pg_ext_pull: assert property (
    pg_state == PG_RELEASED && !pg_in && !pg_drop
    |=> pg_state == PG_HELD)
    else $error("external pull ignored");
  chk_pg_at_cmd: assert property (
    turn_off_cmd && monitor_options[OPT_PG_AT_CMD] |=> !pg_oe_n)
    else $error("power-good not dropped at turn-off");
  chk_retry_pulse: assert property (
    retry_fire |=> restart_req ##1 !restart_req)
    else $error("retry restart pulse wrong");

  cov_oc_trip: cover property (oc_evt ##1 switches_off_now);
  cov_pg_release: cover property (pg_state == PG_DELAY
                                  ##1 pg_state == PG_RELEASED);
  cov_retry: cover property (retry_fire ##1 restart_req);
  cov_tr_fault: cover property (tr_evt ##1 flt_tr);
endmodule

/* File: cfm_pg_partner.sv */
module cfm_pg_partner (
  input wire logic pg_out,  // device drive value
  input wire logic pg_oe_n, // low while device sinks the pin
  input wire logic ext_low, // outside circuit sinks the pin
  output logic pg_wire      // resolved pin level
);
  timeunit 1ns;
  timeprecision 1ps;
  // open collector: pull-up wins unless someone sinks the wire
  assign pg_wire = (pg_oe_n ? 1'b1 : pg_out) & ~ext_low;
endmodule

/* File: tb_converter_fault_warning_monitor.sv */
module tb_converter_fault_warning_monitor import cfm_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk, rst, reg_wr, reg_rd, sample_valid, power_on;
  logic steady_state, ramping_up, ramping_down, above_prebias;
  logic turn_off_cmd, pg_in, ext_low, pg_out, pg_oe_n;
  logic switches_off_now, ramp_down_req, restart_req;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, temp_c, d;
  logic [15:0] vout_mv, vset_mv, vtarget_mv, iout_ma;
  logic [2:0] load_regulation_slope;
  int err_total, check_count, cyc, restarts, r0, i;

  // ------------------------------------------------------------
  // design and pin partner
  // ------------------------------------------------------------
  cfm_fault_monitor #(.MS_TICK_CYCLES(4)) u_cfm_fault_monitor (
    .ref_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .sample_valid, .vout_mv, .vset_mv, .vtarget_mv,
    .iout_ma, .temp_c, .power_on, .steady_state, .ramping_up,
    .ramping_down, .above_prebias, .turn_off_cmd, .pg_in, .pg_out,
    .pg_oe_n, .switches_off_now, .ramp_down_req, .restart_req,
    .load_regulation_slope);
  cfm_pg_partner u_cfm_pg_partner (
    .pg_out(pg_out), .pg_oe_n(pg_oe_n), .ext_low(ext_low),
    .pg_wire(pg_in));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  // restart pulses are counted so a one-cycle pulse is never missed
  always @(posedge ref_clk) begin
    cyc++;
    if (restart_req === 1'b1) restarts++;
    if (cyc == 3000) begin
      err_total++;
      test_done();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  task rd(input logic [7:0] a);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task tk(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  // measurement taken at the second edge, answer seen one cycle later
  task smp;
    @(posedge ref_clk);
    sample_valid <= 1'b1;
    @(posedge ref_clk);
    sample_valid <= 1'b0;
    tk(1);
  endtask

  task wait_restart;
    for (i = 0; i < 700 && restarts == r0; i++) @(posedge ref_clk);
    #1;
  endtask

  task test_done;
    if (err_total == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    {rst, reg_wr, reg_rd, sample_valid, power_on, steady_state} = 6'h21;
    {ramping_up, ramping_down, above_prebias, turn_off_cmd} = 4'h0;
    {ext_low, reg_addr, reg_wdata, temp_c} = {1'b0, 16'h0000, 8'h19};
    {vout_mv, vset_mv, vtarget_mv, iout_ma} = {16'd1000, 16'd1000,
                                               16'd1000, 16'h0000};
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    power_on <= 1'b1;
    steady_state <= 1'b1;
    rd(ADDR_CLS);
    chk(d, 16'h001B);
    rd(ADDR_STATUS);
    chk(d, 16'h00FE);
    rd(8'h55);
    chk(d, 16'h0000);
    chk(load_regulation_slope, 16'h0000);
    // read first so the compensation bit survives the rewrite
    rd(ADDR_CLS);
    wr(ADDR_CLS, {3'h7, d[4], 4'h0});
    rd(ADDR_CLS);
    chk(d, 16'h00F0);
    chk(load_regulation_slope, 16'h0007);
    smp();
    tk(4);
    chk(pg_oe_n, 16'h0001);
    vout_mv <= 16'd1060;
    smp();
    tk(2);
    chk(pg_oe_n, 16'h0000);
    chk({switches_off_now, ramp_down_req}, 16'h0000);
    rd(ADDR_STATUS);
    chk(d & 8'h40, 16'h0000);
    wr(ADDR_OPTIONS, 8'h01);
    smp();
    tk(2);
    chk(pg_oe_n, 16'h0001);
    ext_low <= 1'b1;
    tk(3);
    chk(pg_oe_n, 16'h0000);
    ext_low <= 1'b0;
    vout_mv <= 16'd1000;
    smp();
    tk(2);
    chk(pg_oe_n, 16'h0001);
    above_prebias <= 1'b1;
    iout_ma <= 16'd7399;
    smp();
    chk(switches_off_now, 16'h0000);
    iout_ma <= 16'd7400;
    smp();
    chk(switches_off_now, 16'h0001);
    rd(ADDR_STATUS);
    chk(d & 8'h08, 16'h0000);
    iout_ma <= 16'h0000;
    r0 = restarts;
    wait_restart();
    chk(restarts - r0, 16'h0001);
    chk(switches_off_now, 16'h0000);
    temp_c <= 8'd121;
    smp();
    chk(ramp_down_req, 16'h0001);
    rd(ADDR_STATUS);
    chk(d & 8'h90, 16'h0000);
    temp_c <= 8'd115;
    smp();
    rd(ADDR_STATUS);
    chk(d & 8'h90, 16'h0080);
    r0 = restarts;
    temp_c <= 8'd109;
    smp();
    wait_restart();
    chk(restarts - r0, 16'h0001);
    steady_state <= 1'b0;
    ramping_up <= 1'b1;
    vout_mv <= 16'd1251;
    smp();
    chk(switches_off_now, 16'h0000);
    wr(ADDR_PC1, 8'hA0);
    smp();
    chk(switches_off_now, 16'h0001);
    rd(ADDR_STATUS);
    chk(d & 8'h20, 16'h0000);
    vout_mv <= 16'd1000;
    smp();
    wr(ADDR_STATUS, 8'h20);
    rd(ADDR_STATUS);
    chk(d & 8'h20, 16'h0020);
    // latching undervoltage, sequenced first, then critical style
    wr(ADDR_PC1, 8'hA4);
    ramping_up <= 1'b0;
    steady_state <= 1'b1;
    vout_mv <= 16'd800;
    smp();
    chk({switches_off_now, ramp_down_req}, 16'h0001);
    wr(ADDR_OPTIONS, 8'h05);
    tk(1);
    chk({switches_off_now, ramp_down_req}, 16'h0002);
    vout_mv <= 16'd1000;
    wr(ADDR_STATUS, 8'h04);
    rd(ADDR_STATUS);
    chk(d & 8'h04, 16'h0004);
    // compensation lifts the 37% limit above 7400 mA when warm
    temp_c <= 8'd65;
    iout_ma <= 16'd7400;
    smp();
    chk(switches_off_now, 16'h0000);
    iout_ma <= 16'h0000;
    // power-good drop at the command, then at ramp-down
    wr(ADDR_OPTIONS, 8'h11);
    tk(2);
    chk(pg_oe_n, 16'h0001);
    turn_off_cmd <= 1'b1;
    tk(2);
    chk(pg_oe_n, 16'h0000);
    wr(ADDR_OPTIONS, 8'h01);
    tk(3);
    chk(pg_oe_n, 16'h0001);
    ramping_down <= 1'b1;
    tk(2);
    chk(pg_oe_n, 16'h0000);
    chk(pg_out, 16'h0000);
    test_done();
  end
endmodule
